// *** hw/xifc_top.sv ***
// Execute-in-place start-up command sequencer with APB registers
//
// Functional notes
// - With the status-check bit 28 set, the flash status is read and checked after the commands.
// - Count field 27-26 selects three, two, one or no commands (11, 10, 01, 00).
// - Type field 25-24 selects single, dual or quad lanes; 11 is reserved.
// - Opcode in bits 7-0 goes first, bits 15-8 second, bits 23-16 last.
// - The sequence runs only in execute-in-place mode, before any flash read or write.
// - Bits 31-29 of the control register are not implemented and read as zero.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module xifc_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic flash_rd_req_i,
  output logic flash_rd_grant_o,
  output logic init_done_o,
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  input wire logic [3:0] io_i
);
  import xifc_pkg::*;

  // ==========================================================
  // Registers and state
  logic [31:0] ctrl_r;
  logic xip_en_r;
  logic done_r;
  logic ok_r;
  logic [1:0] idx_r;
  logic [7:0] fstat_r;
  logic start_r;
  logic start_nxt;
  xifc_state_t st_r;
  xifc_state_t st_nxt;
  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_rx;
  logic [7:0] sh_byte;
  xifc_lane_t ctrl_lane;
  logic [1:0] ctrl_count;
  logic ctrl_scheck;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_mode;
  logic busy_flag;

  assign ctrl_lane = xifc_lane_t'(ctrl_r[XIFC_TYPE_LSB +: 2]);
  assign ctrl_count = ctrl_r[XIFC_COUNT_LSB +: 2];
  assign ctrl_scheck = ctrl_r[XIFC_SCHECK_BIT];
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && pready_o;
  assign hit_ctrl = (paddr_i == XIFC_CTRL_OFF);
  assign hit_mode = (paddr_i == XIFC_MODE_OFF);
  assign busy_flag = (st_r != XIFC_ST_IDLE) && (st_r != XIFC_ST_DONE);

  // ==========================================================
  // APB slave: zero wait states, read data staged in setup
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= 1'b1;
      if (setup) begin
        pslverr_o <= !(hit_ctrl || hit_mode);
        prdata_o <= 32'h0000_0000;
        if (!pwrite_i && hit_ctrl) begin
          prdata_o <= ctrl_r & XIFC_CTRL_WMASK;
        end else if (!pwrite_i && hit_mode) begin
          prdata_o[XIFC_XIPEN_BIT] <= xip_en_r;
          prdata_o[XIFC_DONE_BIT] <= done_r;
          prdata_o[XIFC_BUSY_BIT] <= busy_flag;
          prdata_o[XIFC_FSTAT_LSB +: 8] <= fstat_r;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= XIFC_CTRL_RST;
    end else if (access && pwrite_i && hit_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_i[b]) begin
          ctrl_r[b*8 +: 8] <= pwdata_i[b*8 +: 8] & XIFC_CTRL_WMASK[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xip_en_r <= 1'b0;
    end else if (access && pwrite_i && hit_mode && pstrb_i[0]) begin
      xip_en_r <= pwdata_i[XIFC_XIPEN_BIT];
    end
  end

  // ==========================================================
  // Sequencer; gap state decides what follows each step
  always_comb begin
    st_nxt = st_r;
    start_nxt = 1'b0;
    unique case (st_r)
      XIFC_ST_IDLE: begin
        if (xip_en_r) begin
          st_nxt = XIFC_ST_GAP;
        end
      end
      XIFC_ST_GAP: begin
        if (idx_r < ctrl_count) begin
          st_nxt = XIFC_ST_CMD;
          start_nxt = 1'b1;
        end else if (ctrl_scheck && !ok_r) begin
          st_nxt = XIFC_ST_STOP;
          start_nxt = 1'b1;
        end else begin
          st_nxt = XIFC_ST_DONE;
        end
      end
      XIFC_ST_CMD: begin
        if (sh_done) begin
          st_nxt = XIFC_ST_GAP;
        end
      end
      XIFC_ST_STOP: begin
        if (sh_done) begin
          st_nxt = XIFC_ST_STRD;
          start_nxt = 1'b1;
        end
      end
      XIFC_ST_STRD: begin
        if (sh_done) begin
          st_nxt = XIFC_ST_GAP;
        end
      end
      XIFC_ST_DONE: begin
        if (!xip_en_r) begin
          st_nxt = XIFC_ST_IDLE;
        end
      end
      default: st_nxt = XIFC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= XIFC_ST_IDLE;
      start_r <= 1'b0;
      cs_n_o <= 1'b1;
    end else begin
      st_r <= st_nxt;
      start_r <= start_nxt;
      cs_n_o <= !((st_nxt == XIFC_ST_CMD) || (st_nxt == XIFC_ST_STOP) ||
                  (st_nxt == XIFC_ST_STRD));
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idx_r <= 2'h0;
    end else if (st_r == XIFC_ST_IDLE) begin
      idx_r <= 2'h0;
    end else if (st_r == XIFC_ST_CMD && sh_done) begin
      idx_r <= idx_r + 2'h1;
    end
  end

  // Poll repeats while the flash reports write in progress
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ok_r <= 1'b0;
      fstat_r <= 8'h00;
    end else if (st_r == XIFC_ST_IDLE) begin
      ok_r <= 1'b0;
    end else if (st_r == XIFC_ST_STRD && sh_done) begin
      ok_r <= !sh_rx[XIFC_WIP_BIT];
      fstat_r <= sh_rx;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_r <= 1'b0;
      init_done_o <= 1'b0;
      flash_rd_grant_o <= 1'b0;
    end else begin
      done_r <= (st_nxt == XIFC_ST_DONE);
      init_done_o <= (st_nxt == XIFC_ST_DONE);
      flash_rd_grant_o <= flash_rd_req_i && done_r && xip_en_r;
    end
  end

  // ==========================================================
  // Byte and lane selection; status traffic is always single lane
  always_comb begin
    if (st_r == XIFC_ST_STOP) begin
      sh_byte = XIFC_STATUS_OPCODE;
    end else if (idx_r == 2'h0) begin
      sh_byte = ctrl_r[XIFC_OP1_LSB +: 8];
    end else if (idx_r == 2'h1) begin
      sh_byte = ctrl_r[XIFC_OP2_LSB +: 8];
    end else begin
      sh_byte = ctrl_r[XIFC_OP3_LSB +: 8];
    end
  end

  xifc_shift u_shift (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(start_r),
    .byte_i(sh_byte),
    .mode_i((st_r == XIFC_ST_CMD) ? ctrl_lane : XIFC_LANE_SINGLE),
    .rx_i(st_r == XIFC_ST_STRD),
    .io_i(io_i),
    .busy_o(sh_busy),
    .done_o(sh_done),
    .sck_o(sck_o),
    .io_o(io_o),
    .io_oe_n_o(io_oe_n_o),
    .rx_byte_o(sh_rx)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ctrl_top_zero_a: assert property (
    access && !pwrite_i && hit_ctrl |-> prdata_o[31:29] == 3'h0)
    else $error("unimplemented control bits read nonzero");
  ctrl_store_a: assert property (
    ctrl_r[31:29] == 3'h0)
    else $error("unimplemented control bits stored");
  no_check_skip_a: assert property (
    st_r == XIFC_ST_GAP && idx_r >= ctrl_count && !ctrl_scheck |=> st_r == XIFC_ST_DONE)
    else $error("done not reached with status check off");
  check_start_a: assert property (
    st_r == XIFC_ST_GAP && idx_r >= ctrl_count && ctrl_scheck && !ok_r
    |=> st_r == XIFC_ST_STOP ##1 start_r == 1'b0 && !cs_n_o)
    else $error("status check not started");
  status_lane_a: assert property (
    start_r && st_r == XIFC_ST_STOP
    |=> io_oe_n_o == 4'hE && io_o[0] == XIFC_STATUS_OPCODE[7])
    else $error("status opcode not on single lane");
  status_read_a: assert property (
    start_r && st_r == XIFC_ST_STRD |=> io_oe_n_o == XIFC_OE_NONE)
    else $error("lanes driven during status read");
  count_issue_a: assert property (
    st_r == XIFC_ST_GAP && idx_r < ctrl_count |=> st_r == XIFC_ST_CMD && start_r)
    else $error("pending command not issued");
  count_bound_a: assert property (
    start_r && st_r == XIFC_ST_CMD && $stable(ctrl_r) |-> idx_r < ctrl_count)
    else $error("command issued beyond the count");
  lane_oe_a: assert property (
    start_r && st_r == XIFC_ST_CMD && ctrl_lane == XIFC_LANE_QUAD
    |=> io_oe_n_o == 4'h0 ##1 sck_o)
    else $error("quad lanes not driven");
  dual_oe_a: assert property (
    start_r && st_r == XIFC_ST_CMD && ctrl_lane == XIFC_LANE_DUAL
    |=> io_oe_n_o == 4'hC ##1 sck_o)
    else $error("dual lanes not driven");
  single_oe_a: assert property (
    start_r && st_r == XIFC_ST_CMD && (ctrl_lane == XIFC_LANE_SINGLE || ctrl_lane == XIFC_LANE_RSVD)
    |=> io_oe_n_o == 4'hE)
    else $error("single lane not driven alone");
  first_opcode_a: assert property (
    start_r && st_r == XIFC_ST_CMD && idx_r == 2'h0 && ctrl_lane == XIFC_LANE_SINGLE
    |=> io_o[0] == $past(ctrl_r[7]))
    else $error("first opcode msb not on lane 0");
  second_opcode_a: assert property (
    start_r && st_r == XIFC_ST_CMD && idx_r == 2'h1 && ctrl_lane == XIFC_LANE_SINGLE
    |=> io_o[0] == $past(ctrl_r[15]))
    else $error("second opcode msb not on lane 0");
  third_opcode_a: assert property (
    start_r && st_r == XIFC_ST_CMD && idx_r == 2'h2 && ctrl_lane == XIFC_LANE_SINGLE
    |=> io_o[0] == $past(ctrl_r[23]))
    else $error("third opcode msb not on lane 0");
  xip_only_a: assert property (
    st_r == XIFC_ST_IDLE && !xip_en_r |=> st_r == XIFC_ST_IDLE)
    else $error("sequence left idle outside xip mode");
  idle_cs_a: assert property (
    st_r == XIFC_ST_IDLE |-> cs_n_o)
    else $error("chip select low while idle");
  grant_after_a: assert property (
    flash_rd_grant_o |-> $past(done_r) && !busy_flag)
    else $error("read granted before init finished");
  cs_shift_a: assert property (
    sh_busy |-> !cs_n_o)
    else $error("shifting with chip select high");

  // Cover points for the main scenarios
  quad_cmd_c: cover property (start_r && st_r == XIFC_ST_CMD && ctrl_lane == XIFC_LANE_QUAD);
  rsvd_cmd_c: cover property (start_r && st_r == XIFC_ST_CMD && ctrl_lane == XIFC_LANE_RSVD);
  poll_c: cover property (st_r == XIFC_ST_STRD && sh_done && sh_rx[XIFC_WIP_BIT]);
  three_c: cover property (st_r == XIFC_ST_CMD && idx_r == 2'h2 && sh_done);
  grant_c: cover property (flash_rd_grant_o);
endmodule : xifc_top

// *** hw/xifc_pkg.sv ***
// Shared constants and types for the execute-in-place init command stage
package xifc_pkg;
  // ==========================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0] XIFC_CTRL_OFF = 8'h00;
  localparam logic [7:0] XIFC_MODE_OFF = 8'h04;
  localparam logic [31:0] XIFC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] XIFC_CTRL_WMASK = 32'h1FFF_FFFF;
  // ==========================================================
  // Control register fields
  localparam int XIFC_SCHECK_BIT = 28;
  localparam int XIFC_COUNT_LSB = 26;
  localparam int XIFC_TYPE_LSB = 24;
  localparam int XIFC_OP3_LSB = 16;
  localparam int XIFC_OP2_LSB = 8;
  localparam int XIFC_OP1_LSB = 0;
  // ==========================================================
  // Mode/status register fields
  localparam int XIFC_XIPEN_BIT = 0;
  localparam int XIFC_DONE_BIT = 1;
  localparam int XIFC_BUSY_BIT = 2;
  localparam int XIFC_FSTAT_LSB = 8;
  // ==========================================================
  // Flash status polling, released-lane enables and shift step counts
  localparam logic [7:0] XIFC_STATUS_OPCODE = 8'h05;
  localparam int XIFC_WIP_BIT = 0;
  localparam logic [3:0] XIFC_OE_NONE = 4'hF;
  localparam logic [2:0] XIFC_STEPS_SINGLE = 3'h7;
  localparam logic [2:0] XIFC_STEPS_DUAL = 3'h3;
  localparam logic [2:0] XIFC_STEPS_QUAD = 3'h1;

  typedef enum logic [1:0] {
    XIFC_LANE_SINGLE = 2'h0,
    XIFC_LANE_DUAL = 2'h1,
    XIFC_LANE_QUAD = 2'h2,
    XIFC_LANE_RSVD = 2'h3
  } xifc_lane_t;

  typedef enum logic [2:0] {
    XIFC_ST_IDLE = 3'h0,
    XIFC_ST_GAP = 3'h1,
    XIFC_ST_CMD = 3'h3,
    XIFC_ST_STOP = 3'h2,
    XIFC_ST_STRD = 3'h6,
    XIFC_ST_DONE = 3'h7
  } xifc_state_t;
endpackage : xifc_pkg

// *** hw/xifc_shift.sv ***
// Byte shifter for the serial flash lanes with clock divided by two
`timescale 1ns/1ps
module xifc_shift (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  input wire xifc_pkg::xifc_lane_t mode_i,
  input wire logic rx_i,
  input wire logic [3:0] io_i,
  output logic busy_o,
  output logic done_o,
  output logic sck_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  output logic [7:0] rx_byte_o
);
  import xifc_pkg::*;

  logic ph_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  xifc_lane_t mode_r;

  function automatic logic [3:0] lanes_f(input logic [7:0] b, input xifc_lane_t m);
    case (m)
      XIFC_LANE_DUAL: lanes_f = {2'h0, b[7:6]};
      XIFC_LANE_QUAD: lanes_f = b[7:4];
      default: lanes_f = {3'h0, b[7]};
    endcase
  endfunction : lanes_f

  function automatic logic [3:0] oe_f(input xifc_lane_t m);
    case (m)
      XIFC_LANE_DUAL: oe_f = 4'hC;
      XIFC_LANE_QUAD: oe_f = 4'h0;
      default: oe_f = 4'hE;
    endcase
  endfunction : oe_f

  function automatic logic [2:0] steps_f(input xifc_lane_t m);
    case (m)
      XIFC_LANE_DUAL: steps_f = XIFC_STEPS_DUAL;
      XIFC_LANE_QUAD: steps_f = XIFC_STEPS_QUAD;
      default: steps_f = XIFC_STEPS_SINGLE;
    endcase
  endfunction : steps_f

  always_comb begin
    case (mode_r)
      XIFC_LANE_DUAL: sh_nxt = {sh_r[5:0], 2'h0};
      XIFC_LANE_QUAD: sh_nxt = {sh_r[3:0], 4'h0};
      default: sh_nxt = {sh_r[6:0], 1'b0};
    endcase
  end

  // ==========================================================
  // Two clocks per shift step (one, two or four bits by lane type): drive on low phase, sample on rising edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      sck_o <= 1'b0;
      ph_r <= 1'b0;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      mode_r <= XIFC_LANE_SINGLE;
      io_o <= 4'h0;
      io_oe_n_o <= XIFC_OE_NONE;
      rx_byte_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        ph_r <= 1'b0;
        sh_r <= byte_i;
        mode_r <= rx_i ? XIFC_LANE_SINGLE : mode_i;
        cnt_r <= rx_i ? XIFC_STEPS_SINGLE : steps_f(mode_i);
        io_o <= rx_i ? 4'h0 : lanes_f(byte_i, mode_i);
        io_oe_n_o <= rx_i ? XIFC_OE_NONE : oe_f(mode_i);
      end else if (busy_o && !ph_r) begin
        ph_r <= 1'b1;
        sck_o <= 1'b1;
        rx_byte_o <= {rx_byte_o[6:0], io_i[1]};
      end else if (busy_o) begin
        ph_r <= 1'b0;
        sck_o <= 1'b0;
        if (cnt_r == 3'h0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          io_oe_n_o <= XIFC_OE_NONE;
        end else begin
          cnt_r <= cnt_r - 3'h1;
          sh_r <= sh_nxt;
          io_o <= lanes_f(sh_nxt, mode_r);
        end
      end
    end
  end
endmodule : xifc_shift

// *** sim/xifc_flash_model.sv ***
// Behavioural serial flash that captures command bytes and answers status reads
`timescale 1ns/1ps
module xifc_flash_model (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  input wire logic [1:0] lane_i,
  input wire logic [3:0] busy_reads_i,
  input wire logic clr_i,
  output logic [3:0] io_o,
  output logic [7:0] byte_o,
  output logic tgl_o
);
  logic [7:0] sh;
  logic [7:0] stat;
  logic rd;
  int nb;
  int reads;
  // ==========================================================
  // Frame bookkeeping
  initial begin
    io_o = 4'hA;
    tgl_o = 1'b0;
    byte_o = 8'h00;
    rd = 1'b0;
    nb = 0;
    reads = 0;
  end
  always @(posedge clr_i) reads = 0;
  always @(negedge cs_n_i) begin
    nb = 0;
    rd = 1'b0;
  end
  // Released lines flip so a stale value never looks valid
  always @(posedge cs_n_i) begin
    io_o = ~io_o;
    rd = 1'b0;
  end
  // ==========================================================
  // Capture on the rising clock, MSB first
  always @(posedge sck_i) begin
    if (!cs_n_i && !rd) begin
      case (lane_i)
        2'h1: begin
          sh = {sh[5:0], io_i[1:0]};
          nb = nb + 2;
        end
        2'h2: begin
          sh = {sh[3:0], io_i};
          nb = nb + 4;
        end
        default: begin
          sh = {sh[6:0], io_i[0]};
          nb = nb + 1;
        end
      endcase
      if (nb == 8) begin
        byte_o = sh;
        tgl_o = ~tgl_o;
        nb = 0;
        if (sh == 8'h05) begin
          rd = 1'b1;
          stat = (reads < int'(busy_reads_i)) ? 8'h01 : 8'h00;
          reads = reads + 1;
        end
      end
    end
  end
  // Status bits change on the falling clock, ahead of sampling
  always @(negedge sck_i) begin
    if (rd) begin
      io_o[1] = stat[7];
      stat = {stat[6:0], 1'b0};
    end
  end
endmodule : xifc_flash_model

// *** sim/xifc_top_tb.sv ***
// Self-checking bench for the start-up command sequencer
`timescale 1ns/1ps
module xifc_top_tb;
  import xifc_pkg::*;
  logic clk_i;
  logic nrst_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0] pstrb_i;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic flash_rd_req_i;
  logic flash_rd_grant_o;
  logic init_done_o;
  logic cs_n_o;
  logic sck_o;
  logic [3:0] io_o;
  logic [3:0] io_oe_n_o;
  logic [3:0] io_i;
  logic [1:0] lane;
  logic [3:0] busy_reads;
  logic clr;
  logic [7:0] got;
  logic got_tgl;
  logic prev_done;
  logic [7:0] exp_q[$];
  logic [31:0] rd;
  logic er;
  logic sc_run;
  logic [3:0] exp_oe;
  int mismatches;
  int num_checks;

  xifc_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .flash_rd_req_i(flash_rd_req_i), .flash_rd_grant_o(flash_rd_grant_o),
    .init_done_o(init_done_o), .cs_n_o(cs_n_o), .sck_o(sck_o), .io_o(io_o),
    .io_oe_n_o(io_oe_n_o), .io_i(io_i));
  xifc_flash_model i_flash (.cs_n_i(cs_n_o), .sck_i(sck_o), .io_i(io_o), .lane_i(lane),
    .busy_reads_i(busy_reads), .clr_i(clr), .io_o(io_i), .byte_o(got), .tgl_o(got_tgl));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Comparison and verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // ==========================================================
  // APB master, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      close_out();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  // ==========================================================
  // Monitors: flash bytes against notes, read gate against done
  always @(got_tgl) begin
    if (nrst_i === 1'b1) begin
      if (exp_q.size() == 0) chk({24'h0, got}, 32'hFFFF_FFFF);
      else chk({24'h0, got}, {24'h0, exp_q.pop_front()});
    end
  end
  always @(posedge clk_i) begin
    if (nrst_i === 1'b1 && flash_rd_grant_o === 1'b1) chk({31'h0, prev_done}, 32'h1);
    prev_done <= init_done_o;
  end
  // Enables follow the lane type on every command bit; status runs skipped
  always @(posedge sck_o) begin
    if (nrst_i === 1'b1 && cs_n_o === 1'b0 && sc_run === 1'b0) begin
      chk({28'h0, io_oe_n_o}, {28'h0, exp_oe});
    end
  end
  // ==========================================================
  // One start-up sequence with random opcodes
  task automatic run(input logic [1:0] cnt, input logic [1:0] ln, input logic sc,
                     input logic [3:0] busy);
    logic [7:0] op [3];
    logic [31:0] c;
    int n;
    for (int i = 0; i < 3; i++) op[i] = 8'($urandom_range(255, 6));
    c = {3'h7, sc, cnt, ln, op[2], op[1], op[0]};
    lane <= ln;
    busy_reads <= busy;
    sc_run <= sc;
    exp_oe <= (ln == 2'h2) ? 4'h0 : ((ln == 2'h1) ? 4'hC : 4'hE);
    clr <= 1'b1;
    apb(1'b1, XIFC_CTRL_OFF, c, rd, er);
    clr <= 1'b0;
    apb(1'b0, XIFC_CTRL_OFF, 32'h0, rd, er);
    chk(rd, c & XIFC_CTRL_WMASK);
    repeat (20) @(posedge clk_i);
    for (int i = 0; i < int'(cnt); i++) exp_q.push_back(op[i]);
    if (sc) for (int i = 0; i <= int'(busy); i++) exp_q.push_back(XIFC_STATUS_OPCODE);
    apb(1'b1, XIFC_MODE_OFF, 32'h1, rd, er);
    n = 0;
    while (init_done_o !== 1'b1 && n < 3000) begin
      flash_rd_req_i <= 1'($urandom);
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      close_out();
    end
    chk(32'(exp_q.size()), 32'h0);
    flash_rd_req_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, flash_rd_grant_o}, 32'h1);
    apb(1'b0, XIFC_MODE_OFF, 32'h0, rd, er);
    chk({29'h0, rd[2:0]}, 32'h3);
    if (sc) chk({24'h0, rd[15:8]}, 32'h0);
    apb(1'b1, XIFC_MODE_OFF, 32'h0, rd, er);
  endtask : run
  // ==========================================================
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    pstrb_i = 4'hF;
    flash_rd_req_i = 1'b0;
    lane = 2'h0;
    busy_reads = 4'h0;
    clr = 1'b0;
    prev_done = 1'b0;
    sc_run = 1'b0;
    exp_oe = 4'hE;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(32'h037A));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, XIFC_CTRL_OFF, 32'h0, rd, er);
    chk(rd, XIFC_CTRL_RST);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, XIFC_CTRL_OFF, 32'h0, rd, er);
    chk(rd, XIFC_CTRL_RST);
    for (int c = 0; c < 4; c++) for (int l = 0; l < 4; l++) run(2'(c), 2'(l), 1'b0, 4'h0);
    run(2'h3, 2'h0, 1'b1, 4'h0);
    run(2'h2, 2'h0, 1'b1, 4'h2);
    run(2'h0, 2'h0, 1'b1, 4'h1);
    close_out();
  end
endmodule : xifc_top_tb
